// ### design/utx_map.svh
// register offsets, field positions and reset values of the transmit endpoint
// assumes byte-wide register accesses with a 10-bit offset
`ifndef UTX_MAP_SVH
`define UTX_MAP_SVH

`define UTX_OFF_LO      10'h112
`define UTX_OFF_HI1     10'h113
`define UTX_OFF_HI2     10'h123
`define UTX_OFF_HI3     10'h133

`define UTX_LO_STALLED  5
`define UTX_LO_STALL    4
`define UTX_LO_FLUSH    3
`define UTX_LO_UNDERRUN 2
`define UTX_LO_FIFO_NOT_EMPTY   1
`define UTX_LO_TX_PACKET_READY    0

`define UTX_HI_AUTO     7
`define UTX_HI_ISO      6
`define UTX_HI_MODE     5
`define UTX_HI_DMA_REQUEST_ENABLE    4
`define UTX_HI_WMASK    8'hF0

`define UTX_RST_BYTE    8'h00

`endif

// ### design/utx_pkg.sv
// types shared by both ends of the transmit endpoint link
// assumes nothing beyond a SystemVerilog compiler
package utx_pkg;

	typedef enum logic [1:0] {
		UTX_IDLE,
		UTX_SEND,
		UTX_WAIT_ACK
	} utx_state_e;

	typedef logic [7:0] utx_byte_t;

endpackage : utx_pkg

// ### design/utx_link_if.sv
// link between the endpoint (dev) and the far usb party (host)
// assumes both ends run on the same mclk
`timescale 1ns/1ns
interface utx_link_if;
	import utx_pkg::*;

	logic      in_token;
	logic      ack;
	logic      rx_ready;
	logic      tx_valid;
	utx_byte_t tx_data;
	logic      tx_last;
	logic      stall_hs;
	logic      nak_hs;

	modport dev (
		input  in_token,
		input  ack,
		input  rx_ready,
		output tx_valid,
		output tx_data,
		output tx_last,
		output stall_hs,
		output nak_hs
	);

	modport host (
		output in_token,
		output ack,
		output rx_ready,
		input  tx_valid,
		input  tx_data,
		input  tx_last,
		input  stall_hs,
		input  nak_hs
	);

endinterface : utx_link_if

// ### design/utx_endpoint.sv
// transmit endpoint control/status logic with two packet slots
// assumes register accesses synchronous to mclk, one per cycle
// What this block does
// - stall sent sets flag, flushes, clears ready
// - send_stall answers in tokens with stall
// - isochronous endpoint ignores send_stall
// - flush drops latest packet, clears ready, interrupts
// - flush with ready aborts packet being loaded
// - software flush acts whether or not ready is set
// - in token with no packet held sets underrun
// - fifo_not_empty while a packet is held
// - ready cleared and interrupt after transmission
// - double buffering clears ready for second packet
// - auto_ready_on_full sets ready on full packet
// - direction bit selects transmit on shared fifo
// - dma request only while enabled
// - host-mode bit 6 reads zero
// - three high control bytes, reset zero
`timescale 1ns/1ns
`include "utx_map.svh"
module utx_endpoint
	import utx_pkg::*;
#(
	parameter int MAXP        = 64,
	parameter bit DOUBLE_BUF  = 1'b1,
	parameter bit SHARED_FIFO = 1'b0
) (
	input  wire logic                      mclk,
	input  wire logic                      sys_rst,
	input  wire logic                      host_mode,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [9:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	output      logic [7:0]                reg_rdata,
	input  wire logic                      load_valid,
	input  wire logic [7:0]                load_data,
	output      logic                      load_ready,
	input  wire logic [$clog2(MAXP+1)-1:0] tx_max_packet_size,
	output      logic                      dma_req,
	output      logic                      tx_event,
	utx_link_if.dev                        lnk
);
	localparam int AW = $clog2(MAXP);
	localparam int CW = $clog2(MAXP+1);

	logic [7:0]    high_ctl [3];
	logic          stall_sent;
	logic          send_stall;
	logic          underrun_flag;
	logic          fifo_not_empty;
	logic          tx_packet_ready;
	utx_byte_t     mem [2*MAXP];
	logic [CW-1:0] slot_len [2];
	logic [CW-1:0] wr_cnt;
	logic [CW-1:0] rd_cnt;
	logic          wr_slot;
	logic          rd_slot;
	logic [1:0]    pkt_cnt;
	utx_state_e    state;
	utx_byte_t     bq_data [2];
	logic          bq_last [2];
	logic          bq_wp;
	logic          bq_rp;
	logic [1:0]    bq_cnt;

	logic [7:0]    keep_bits;
	logic lo_wr, flush_wr, ready_wr, abort, commit, load_go, tx_dir;
	logic iso, auto_ready, dma_en, in_ok, stall_ev, under_ev;
	logic done, drop, push, pop, push_last, dbl_clear;
	assign lo_wr    = reg_wr && (reg_addr == `UTX_OFF_LO);
	assign keep_bits = lo_wr ? reg_wdata : 8'hFF;
	assign flush_wr = lo_wr && reg_wdata[`UTX_LO_FLUSH];
	assign ready_wr = lo_wr && reg_wdata[`UTX_LO_TX_PACKET_READY];
	assign abort    = flush_wr && ready_wr;
	assign iso        = high_ctl[0][`UTX_HI_ISO] && !host_mode;
	assign auto_ready = high_ctl[0][`UTX_HI_AUTO];
	assign dma_en     = high_ctl[0][`UTX_HI_DMA_REQUEST_ENABLE];
	assign tx_dir     = !SHARED_FIFO || high_ctl[0][`UTX_HI_MODE];

	assign load_ready = tx_dir && !tx_packet_ready && (pkt_cnt != 2'd2)
		&& (wr_cnt < tx_max_packet_size) && !flush_wr;
	assign load_go    = load_valid && load_ready;
	assign dma_req    = dma_en && load_ready;

	// auto ready on full
	// zero-length packets are never committed
	assign commit = !tx_packet_ready && !flush_wr && (pkt_cnt != 2'd2) && (wr_cnt != '0)
		&& (ready_wr || (auto_ready && wr_cnt == tx_max_packet_size));
	assign dbl_clear = DOUBLE_BUF && tx_packet_ready && (pkt_cnt == 2'd1);

	assign in_ok    = lnk.in_token && tx_dir && (state == UTX_IDLE);
	assign stall_ev = in_ok && send_stall && !iso;
	assign under_ev = in_ok && !stall_ev && (pkt_cnt == 2'd0);
	assign done     = (state == UTX_WAIT_ACK) && lnk.ack;
	assign drop     = flush_wr && !abort && (pkt_cnt != 2'd0);

	assign push      = (state == UTX_SEND) && (bq_cnt != 2'd2);
	assign push_last = (rd_cnt + 1'b1) == slot_len[rd_slot];
	assign pop       = lnk.tx_valid && lnk.rx_ready;

	assign lnk.tx_valid = (bq_cnt != 2'd0);
	assign lnk.tx_data  = bq_data[bq_rp];
	assign lnk.tx_last  = bq_last[bq_rp];
	assign lnk.stall_hs = stall_ev;
	assign lnk.nak_hs   = under_ev;
	for (genvar gi = 0; gi < 3; gi++) begin : g_high
		localparam logic [9:0] OFF = `UTX_OFF_HI1 + 10'(gi * 16);
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				high_ctl[gi] <= `UTX_RST_BYTE;
			end else if (reg_wr && reg_addr == OFF) begin
				high_ctl[gi] <= reg_wdata & `UTX_HI_WMASK;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stall_sent     <= 1'b0;
			underrun_flag  <= 1'b0;
			fifo_not_empty <= 1'b0;
			send_stall     <= 1'b0;
		end else begin
			stall_sent     <= stall_ev || (stall_sent && keep_bits[`UTX_LO_STALLED]);
			underrun_flag  <= under_ev || (underrun_flag && keep_bits[`UTX_LO_UNDERRUN]);
			fifo_not_empty <= (pkt_cnt != 2'd0) || (fifo_not_empty && keep_bits[`UTX_LO_FIFO_NOT_EMPTY]);
			if (lo_wr) begin
				send_stall <= reg_wdata[`UTX_LO_STALL];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tx_packet_ready <= 1'b0;
		end else if (stall_ev || flush_wr) begin
			tx_packet_ready <= 1'b0;
		end else if (commit) begin
			tx_packet_ready <= 1'b1;
		end else if (done || dbl_clear) begin
			// a ready write in the ack cycle must not be lost
			tx_packet_ready <= 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		tx_event <= !sys_rst && (flush_wr || done);
	end
	always_ff @(posedge mclk) begin
		if (load_go) begin
			mem[{wr_slot, wr_cnt[AW-1:0]}] <= load_data;
		end
	end

	// slot bookkeeping; a flush while sending the only packet aborts it
	always_ff @(posedge mclk) begin
		if (sys_rst || stall_ev) begin
			wr_cnt   <= '0;
			wr_slot  <= 1'b0;
			rd_slot  <= 1'b0;
			pkt_cnt  <= 2'd0;
			slot_len <= '{default: '0};
		end else if (flush_wr) begin
			wr_cnt <= '0;
			// an ack in the flush cycle still frees its slot
			if (done && !(drop && pkt_cnt == 2'd1)) begin
				rd_slot <= ~rd_slot;
			end
			if (drop) begin
				wr_slot <= ~wr_slot;
			end
			pkt_cnt <= pkt_cnt - {1'b0, drop} - {1'b0, done && !(drop && pkt_cnt == 2'd1)};
		end else begin
			if (commit) begin
				slot_len[wr_slot] <= wr_cnt;
				wr_slot           <= ~wr_slot;
				wr_cnt            <= '0;
			end else if (load_go) begin
				wr_cnt <= wr_cnt + 1'b1;
			end
			if (done) begin
				rd_slot <= ~rd_slot;
			end
			pkt_cnt <= pkt_cnt + {1'b0, commit} - {1'b0, done};
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || stall_ev || (drop && pkt_cnt == 2'd1)) begin
			state  <= UTX_IDLE;
			rd_cnt <= '0;
		end else begin
			unique case (state)
				UTX_IDLE: begin
					if (in_ok && !stall_ev && !under_ev) begin
						state  <= UTX_SEND;
						rd_cnt <= '0;
					end
				end
				UTX_SEND: begin
					if (push) begin
						rd_cnt <= rd_cnt + 1'b1;
						if (push_last) begin
							state <= UTX_WAIT_ACK;
						end
					end
				end
				UTX_WAIT_ACK: begin
					if (lnk.ack) begin
						state <= UTX_IDLE;
					end
				end
			endcase
		end
	end

	// two-entry buffer: receiver stall holds bytes, send state waits
	always_ff @(posedge mclk) begin
		if (sys_rst || stall_ev || (drop && pkt_cnt == 2'd1)) begin
			bq_wp  <= 1'b0;
			bq_rp  <= 1'b0;
			bq_cnt <= 2'd0;
		end else begin
			if (push) begin
				bq_data[bq_wp] <= mem[{rd_slot, rd_cnt[AW-1:0]}];
				bq_last[bq_wp] <= push_last;
				bq_wp          <= ~bq_wp;
			end
			if (pop) begin
				bq_rp <= ~bq_rp;
			end
			bq_cnt <= bq_cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	// host reads bit 6 as zero
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= `UTX_RST_BYTE;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`UTX_OFF_LO:  reg_rdata <= {2'b00, stall_sent, send_stall, 1'b0,
					underrun_flag, fifo_not_empty, tx_packet_ready};
				`UTX_OFF_HI1: reg_rdata <= {high_ctl[0][7], high_ctl[0][6] && !host_mode,
					high_ctl[0][5:0]};
				`UTX_OFF_HI2: reg_rdata <= {high_ctl[1][7], high_ctl[1][6] && !host_mode,
					high_ctl[1][5:0]};
				`UTX_OFF_HI3: reg_rdata <= {high_ctl[2][7], high_ctl[2][6] && !host_mode,
					high_ctl[2][5:0]};
				default:      reg_rdata <= `UTX_RST_BYTE;
			endcase
		end
	end

endmodule : utx_endpoint

// ### design/utx_far_host.sv
// far usb party: issues in tokens, takes packet bytes, acknowledges
// assumes the endpoint answers each token with stall, nak or data
`timescale 1ns/1ns
module utx_far_host
	import utx_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      sys_rst,
	input  wire logic      in_req,
	input  wire logic      sink_ready,
	output      utx_byte_t rx_data,
	output      logic      rx_valid,
	output      logic      rx_last,
	output      logic      got_stall,
	output      logic      got_nak,
	output      logic      got_packet,
	utx_link_if.host       lnk
);
	logic take;

	assign lnk.rx_ready = sink_ready;
	assign take         = lnk.tx_valid && sink_ready;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lnk.in_token <= 1'b0;
			lnk.ack      <= 1'b0;
			got_stall    <= 1'b0;
			got_nak      <= 1'b0;
			got_packet   <= 1'b0;
		end else begin
			lnk.in_token <= in_req;
			// acknowledge once the last byte is taken
			lnk.ack      <= take && lnk.tx_last;
			got_stall    <= lnk.stall_hs;
			got_nak      <= lnk.nak_hs;
			got_packet   <= take && lnk.tx_last;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_data  <= 8'h00;
			rx_valid <= 1'b0;
			rx_last  <= 1'b0;
		end else begin
			rx_valid <= take;
			if (take) begin
				rx_data <= lnk.tx_data;
				rx_last <= lnk.tx_last;
			end
		end
	end

endmodule : utx_far_host

// ### test/utx_link_sva.sv
// checker of the link between endpoint and far party
// assumes one shared mclk and sys_rst active high
`timescale 1ns/1ns
module utx_link_sva
	import utx_pkg::*;
(
	input wire logic      mclk,
	input wire logic      sys_rst,
	input wire logic      in_token,
	input wire logic      ack,
	input wire logic      rx_ready,
	input wire logic      tx_valid,
	input wire utx_byte_t tx_data,
	input wire logic      tx_last,
	input wire logic      stall_hs,
	input wire logic      nak_hs
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_took_last;
		tx_valid && rx_ready && tx_last;
	endsequence
	// no data may follow a refused token for three cycles
	sequence s_quiet;
		!tx_valid [*3];
	endsequence
	AST_STALL_CAUSE: assert property (stall_hs |-> in_token)
		else $error("stall without token");
	AST_NAK_CAUSE: assert property (nak_hs |-> in_token)
		else $error("nak without token");
	AST_ONE_ANSWER: assert property (!(stall_hs && nak_hs))
		else $error("stall and nak together");
	AST_STALL_QUIET: assert property (stall_hs |=> s_quiet)
		else $error("data after stall");
	AST_NAK_QUIET: assert property (nak_hs |=> s_quiet)
		else $error("data after nak");
	AST_HOLD: assert property (tx_valid && !rx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("byte lost in stall");
	AST_ACK_LAST: assert property (s_took_last |=> ack)
		else $error("no ack after last byte");
	AST_RESET_IDLE: assert property ($fell(sys_rst) |-> !tx_valid && !ack)
		else $error("link busy after reset");
endmodule : utx_link_sva

// ### test/testbench.sv
// self-checking bench: endpoint and far party joined by the link
// assumes the bench alone drives registers, loads and tokens
`timescale 1ns/1ns
module testbench;
	localparam logic [9:0] LO = 10'h112;
	localparam logic [9:0] HI = 10'h113;
	logic       mclk = 1'h0;
	logic       sys_rst = 1'h1;
	logic       host_mode = 1'h0;
	logic       reg_wr = 1'h0;
	logic       reg_rd = 1'h0;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic       load_valid = 1'h0;
	logic [7:0] load_data = 8'h00;
	logic [6:0] maxp = 7'h04;
	logic       in_req = 1'h0;
	logic       sink_ready = 1'h1;
	logic       slow = 1'h0;
	logic [7:0] rx_data;
	logic [7:0] rxq[$];
	logic       load_ready, dma_req, tx_event, rx_valid, got_stall, got_nak, got_packet;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         n_ev = 0;
	utx_link_if lnk ();
	utx_endpoint u_utx_endpoint (.mclk(mclk), .sys_rst(sys_rst), .host_mode(host_mode),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .load_valid(load_valid), .load_data(load_data),
		.load_ready(load_ready), .tx_max_packet_size(maxp), .dma_req(dma_req),
		.tx_event(tx_event), .lnk(lnk));
	utx_far_host u_utx_far_host (.mclk(mclk), .sys_rst(sys_rst), .in_req(in_req),
		.sink_ready(sink_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(),
		.got_stall(got_stall), .got_nak(got_nak), .got_packet(got_packet), .lnk(lnk));
	utx_link_sva u_utx_link_sva (.mclk(mclk), .sys_rst(sys_rst), .in_token(lnk.in_token),
		.ack(lnk.ack), .rx_ready(lnk.rx_ready), .tx_valid(lnk.tx_valid),
		.tx_data(lnk.tx_data), .tx_last(lnk.tx_last), .stall_hs(lnk.stall_hs),
		.nak_hs(lnk.nak_hs));
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (rx_valid === 1'h1) rxq.push_back(rx_data);
	always @(posedge mclk) if (tx_event === 1'h1) n_ev++;
	// receiver stalls every other cycle to exercise the buffer
	always @(posedge mclk) sink_ready <= slow ? ~sink_ready : 1'h1;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(negedge mclk);
		check(reg_rdata, e);
		@(posedge mclk);
	endtask : rd
	task automatic load(input int n);
		for (int i = 0; i < n; i++) begin
			load_valid <= 1'h1;
			load_data <= 8'(8'hA0 + i);
			@(posedge mclk);
		end
		load_valid <= 1'h0;
		@(posedge mclk);
	endtask : load
	// answer seen as {stall, nak, packet}
	task automatic tok(input logic [2:0] e);
		logic [2:0] g;
		g = 3'h0;
		in_req <= 1'h1;
		@(posedge mclk);
		in_req <= 1'h0;
		repeat (40) begin
			@(negedge mclk);
			g = g | {got_stall, got_nak, got_packet};
		end
		check(8'(g), 8'(e));
		@(posedge mclk);
	endtask : tok
	task automatic send(input int n);
		int e;
		e = n_ev;
		rxq.delete();
		tok(3'h1);
		check(8'(rxq.size()), 8'(n));
		foreach (rxq[i]) check(rxq[i], 8'(8'hA0 + i));
		check(8'(n_ev - e), 8'h01);
	endtask : send
	task automatic t_regs();
		logic [9:0] a[5] = '{LO, HI, 10'h123, 10'h133, 10'h120};
		wr(10'h120, 8'hFF);
		foreach (a[i]) rd(a[i], 8'h00);
		wr(10'h133, 8'hFF);
		rd(10'h133, 8'hF0);
		wr(10'h133, 8'h00);
		tok(3'h2);
		rd(LO, 8'h04);
		wr(LO, 8'h00);
		rd(LO, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task automatic t_send();
		load(3);
		wr(LO, 8'h01);
		rd(LO, 8'h02);
		slow <= 1'h1;
		send(3);
		slow <= 1'h0;
		wr(LO, 8'h00);
		rd(LO, 8'h00);
		$display("test send done");
	endtask : t_send
	task automatic t_stall();
		wr(LO, 8'h10);
		tok(3'h4);
		rd(LO, 8'h30);
		tok(3'h4);
		wr(HI, 8'h40);
		tok(3'h2);
		rd(HI, 8'h40);
		host_mode <= 1'h1;
		rd(HI, 8'h00);
		host_mode <= 1'h0;
		wr(HI, 8'h10);
		@(negedge mclk);
		check(dma_req, 8'h01);
		@(posedge mclk);
		wr(HI, 8'h00);
		check(dma_req, 8'h00);
		wr(LO, 8'h00);
		rd(LO, 8'h00);
		$display("test stall done");
	endtask : t_stall
	task automatic t_auto();
		wr(HI, 8'h80);
		load(4);
		// fifo flag trails the auto commit by one edge
		@(posedge mclk);
		rd(LO, 8'h02);
		send(4);
		wr(HI, 8'h00);
		wr(LO, 8'h00);
		$display("test auto done");
	endtask : t_auto
	task automatic t_flush();
		int e;
		load(2);
		wr(LO, 8'h01);
		load(2);
		wr(LO, 8'h01);
		rd(LO, 8'h03);
		e = n_ev;
		wr(LO, 8'h08);
		@(negedge mclk);
		check(8'(n_ev - e), 8'h01);
		rd(LO, 8'h02);
		send(2);
		tok(3'h2);
		load(2);
		wr(LO, 8'h09);
		tok(3'h2);
		wr(LO, 8'h00);
		$display("test flush done");
	endtask : t_flush
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'h0;
		@(posedge mclk);
		t_regs();
		t_send();
		t_stall();
		t_auto();
		t_flush();
		summarize();
	end
endmodule : testbench
